// ---- pkg/focsr_pkg.sv ----
// Package: register indices, codes and reset values of the status readback
`default_nettype none
package focsr_pkg;
  // Printed offsets (indices); byte address is four times the index
  localparam logic [11:0] FOCSR_IDX_FLUX   = 12'h606;
  localparam logic [11:0] FOCSR_IDX_TORQUE = 12'h608;
  localparam logic [11:0] FOCSR_IDX_SDST   = 12'h682;
  localparam logic [11:0] FOCSR_IDX_SDSPD  = 12'h68C;
  localparam logic [11:0] FOCSR_IDX_PDST   = 12'h6C0;
  localparam logic [11:0] FOCSR_IDX_PDANG  = 12'h704;
  // Address width of the register bus (byte address)
  localparam int unsigned FOCSR_AW = 14;
  // Reset values
  localparam logic [31:0] FOCSR_RST_WORD  = 32'h0000_0000;
  localparam logic [15:0] FOCSR_RST_STATE = 16'h0000;
  // AXI response codes
  localparam logic [1:0] FOCSR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] FOCSR_RESP_SLVERR = 2'h2;
  // Speed detection state codes
  localparam logic [15:0] FOCSR_SD_INIT     = 16'h0000;
  localparam logic [15:0] FOCSR_SD_STOPCHK  = 16'h0001;
  localparam logic [15:0] FOCSR_SD_ESTINIT  = 16'h0002;
  localparam logic [15:0] FOCSR_SD_RUNCHK   = 16'h0003;
  localparam logic [15:0] FOCSR_SD_DIRCHK   = 16'h0004;
  localparam logic [15:0] FOCSR_SD_DONE     = 16'h0005;
  localparam logic [15:0] FOCSR_SD_ERROR    = 16'h0006;
  // Position detection state codes (0..A are the sequence steps)
  localparam logic [15:0] FOCSR_PD_INIT     = 16'h0000;
  localparam logic [15:0] FOCSR_PD_ANGCALC  = 16'h000A;
  localparam logic [15:0] FOCSR_PD_DONE     = 16'h000B;
  localparam logic [15:0] FOCSR_PD_ERROR    = 16'h000C;
endpackage : focsr_pkg
`default_nettype wire

// ---- rtl/focsr_top.sv ----
// Status readback register bank of the motor control engine, AXI4-Lite slave
//
// Contract
// - Flux current reference, 32-bit signed, read-only
// - Torque current reference, 32-bit signed, read-only
// - Speed detection state, 16-bit code 0..6
// - Speed detection absolute speed, 32-bit read-only
// - Position detection state, 16-bit code 0..C
// - Position angle read-only at 704h, resets zero
// - Position angle is 32-bit signed degrees
`timescale 1ns/1ps
`default_nettype none
module focsr_top
(
  input  wire logic                  clk,            // System clock
  input  wire logic                  reset,          // Async reset, high
  // Engine side: value and one-cycle update strobe per register
  input  wire logic [31:0]           flux_ref_in,    // Flux reference
  input  wire logic                  flux_ref_we,    // Flux update strobe
  input  wire logic [31:0]           torque_ref_in,  // Torque reference
  input  wire logic                  torque_ref_we,  // Torque update strobe
  input  wire logic [15:0]           sd_state_in,    // Speed detect state
  input  wire logic                  sd_state_we,    // Its strobe
  input  wire logic [31:0]           sd_speed_in,    // Speed detect speed
  input  wire logic                  sd_speed_we,    // Its strobe
  input  wire logic [15:0]           pd_state_in,    // Position detect state
  input  wire logic                  pd_state_we,    // Its strobe
  input  wire logic [31:0]           pd_angle_in,    // Position angle
  input  wire logic                  pd_angle_we,    // Its strobe
  // Status outputs derived from stored codes
  output logic                       speed_detect_done,     // Code 5
  output logic                       speed_detect_error,    // Code 6
  output logic                       position_detect_done,  // Code B
  output logic                       position_detect_error, // Code C
  // AXI4-Lite slave
  input  wire logic [focsr_pkg::FOCSR_AW-1:0] s_axi_awaddr,  // Write addr
  input  wire logic                  s_axi_awvalid,  // Write addr valid
  output logic                       s_axi_awready,  // Write addr ready
  input  wire logic [31:0]           s_axi_wdata,    // Write data
  input  wire logic [3:0]            s_axi_wstrb,    // Byte strobes
  input  wire logic                  s_axi_wvalid,   // Write data valid
  output logic                       s_axi_wready,   // Write data ready
  output logic [1:0]                 s_axi_bresp,    // Write response
  output logic                       s_axi_bvalid,   // Write resp valid
  input  wire logic                  s_axi_bready,   // Write resp ready
  input  wire logic [focsr_pkg::FOCSR_AW-1:0] s_axi_araddr,  // Read addr
  input  wire logic                  s_axi_arvalid,  // Read addr valid
  output logic                       s_axi_arready,  // Read addr ready
  output logic [31:0]                s_axi_rdata,    // Read data
  output logic [1:0]                 s_axi_rresp,    // Read response
  output logic                       s_axi_rvalid,   // Read data valid
  input  wire logic                  s_axi_rready    // Read resp ready
);
  import focsr_pkg::*;

  // ==========================================================
  // Status storage
  // ==========================================================
  logic [31:0] flux_current_reference_reg;    // Signed, 2^27 full scale
  logic [31:0] torque_current_reference_reg;  // Signed, 2^27 full scale
  logic [15:0] speed_detect_state_reg;        // Sequence code
  logic [31:0] speed_detect_speed_reg;        // Absolute speed
  logic [15:0] position_detect_state_reg;     // Sequence code
  logic [31:0] position_detect_angle_reg;     // Signed angle

  // Engine is the only writer; the bus never reaches these flops
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      flux_current_reference_reg   <= FOCSR_RST_WORD;
      torque_current_reference_reg <= FOCSR_RST_WORD;
      speed_detect_state_reg       <= FOCSR_RST_STATE;
      speed_detect_speed_reg       <= FOCSR_RST_WORD;
      position_detect_state_reg    <= FOCSR_RST_STATE;
      position_detect_angle_reg    <= FOCSR_RST_WORD;
    end
    else
    begin
      if (flux_ref_we)
        flux_current_reference_reg <= flux_ref_in;
      if (torque_ref_we)
        torque_current_reference_reg <= torque_ref_in;
      if (sd_state_we)
        speed_detect_state_reg <= sd_state_in;
      if (sd_speed_we)
        speed_detect_speed_reg <= sd_speed_in;
      if (pd_state_we)
        position_detect_state_reg <= pd_state_in;
      if (pd_angle_we)
        position_detect_angle_reg <= pd_angle_in;
    end
  end

  // Flags are flops loaded with the code, so they move with the stored code
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      speed_detect_done     <= 1'b0;
      speed_detect_error    <= 1'b0;
      position_detect_done  <= 1'b0;
      position_detect_error <= 1'b0;
    end
    else
    begin
      if (sd_state_we)
      begin
        speed_detect_done  <= (sd_state_in == FOCSR_SD_DONE);
        speed_detect_error <= (sd_state_in == FOCSR_SD_ERROR);
      end
      if (pd_state_we)
      begin
        position_detect_done  <= (pd_state_in == FOCSR_PD_DONE);
        position_detect_error <= (pd_state_in == FOCSR_PD_ERROR);
      end
    end
  end

  // ==========================================================
  // Write channel: accepted and answered, never stored
  // ==========================================================
  logic aw_held_reg;   // Address taken, waiting for data
  logic w_held_reg;    // Data taken, waiting for address

  // Ready while that half not yet taken and no response pending
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;

  // Collect both halves in either order, then respond
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= FOCSR_RESP_OKAY;
    end
    else if (s_axi_bvalid)
    begin
      if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
    else
    begin
      if ((aw_held_reg || s_axi_awvalid) && (w_held_reg || s_axi_wvalid))
      begin
        // Read-only bank: a write reports an error and changes nothing
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= FOCSR_RESP_SLVERR;
      end
      else
      begin
        if (s_axi_awvalid)
          aw_held_reg <= 1'b1;
        if (s_axi_wvalid)
          w_held_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Read channel: decode byte address, index times four
  // ==========================================================
  logic [31:0] rd_word;   // Selected word
  logic        rd_hit;    // Address maps to a register

  // Address decoding; 16-bit codes sit in the low half
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (s_axi_araddr == {FOCSR_IDX_FLUX, 2'h0})
      rd_word = flux_current_reference_reg;
    else if (s_axi_araddr == {FOCSR_IDX_TORQUE, 2'h0})
      rd_word = torque_current_reference_reg;
    else if (s_axi_araddr == {FOCSR_IDX_SDST, 2'h0})
      rd_word = {16'h0000, speed_detect_state_reg};
    else if (s_axi_araddr == {FOCSR_IDX_SDSPD, 2'h0})
      rd_word = speed_detect_speed_reg;
    else if (s_axi_araddr == {FOCSR_IDX_PDST, 2'h0})
      rd_word = {16'h0000, position_detect_state_reg};
    else if (s_axi_araddr == {FOCSR_IDX_PDANG, 2'h0})
      rd_word = position_detect_angle_reg;
    else
      rd_hit = 1'b0;
  end

  assign s_axi_arready = !s_axi_rvalid;

  // Capture the current value when the address is taken
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= FOCSR_RST_WORD;
      s_axi_rresp  <= FOCSR_RESP_OKAY;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else if (s_axi_arvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? FOCSR_RESP_OKAY : FOCSR_RESP_SLVERR;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  property p_flux_load;
    @(posedge clk) disable iff (reset)
    flux_ref_we |=> flux_current_reference_reg == $past(flux_ref_in);
  endproperty
  a_flux_load: assert property (p_flux_load)
    else $error("flux reference not loaded");

  property p_torque_hold;
    @(posedge clk) disable iff (reset)
    !torque_ref_we |=> $stable(torque_current_reference_reg);
  endproperty
  a_torque_hold: assert property (p_torque_hold)
    else $error("torque reference changed without strobe");

  property p_sd_done;
    @(posedge clk) disable iff (reset)
    sd_state_we && sd_state_in == FOCSR_SD_DONE |=> speed_detect_done;
  endproperty
  a_sd_done: assert property (p_sd_done)
    else $error("speed detect done flag missing");

  property p_sd_speed;
    @(posedge clk) disable iff (reset)
    sd_speed_we |=> speed_detect_speed_reg == $past(sd_speed_in);
  endproperty
  a_sd_speed: assert property (p_sd_speed)
    else $error("speed detect speed not loaded");

  property p_pd_error;
    @(posedge clk) disable iff (reset)
    pd_state_we && pd_state_in == FOCSR_PD_ERROR
      |=> position_detect_error && !position_detect_done;
  endproperty
  a_pd_error: assert property (p_pd_error)
    else $error("position detect error flag wrong");

  property p_angle_read;
    @(posedge clk) disable iff (reset)
    s_axi_arvalid && s_axi_arready
      && s_axi_araddr == {FOCSR_IDX_PDANG, 2'h0}
      |=> s_axi_rvalid && s_axi_rdata == $past(position_detect_angle_reg);
  endproperty
  a_angle_read: assert property (p_angle_read)
    else $error("angle read returned wrong word");

  property p_angle_hold;
    @(posedge clk) disable iff (reset)
    !pd_angle_we |=> $stable(position_detect_angle_reg);
  endproperty
  a_angle_hold: assert property (p_angle_hold)
    else $error("angle changed without strobe");

  property p_write_ignored;
    @(posedge clk) disable iff (reset)
    s_axi_bvalid && !$past(s_axi_bvalid) && !$past(flux_ref_we)
      |-> $stable(flux_current_reference_reg)
        && s_axi_bresp == FOCSR_RESP_SLVERR;
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("host write affected status");

  property p_rd_resp;
    @(posedge clk) disable iff (reset)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_resp: assert property (p_rd_resp)
    else $error("read data dropped before ready");

  c_read: cover property (@(posedge clk) s_axi_rvalid && s_axi_rready);
  c_write: cover property (@(posedge clk) s_axi_bvalid && s_axi_bready);
  c_pd_done: cover property (@(posedge clk) position_detect_done);
endmodule // focsr_top
`default_nettype wire

// ---- testbench/focsr_top_bench.sv ----
// Self-checking bench for the status readback register bank
`timescale 1ns/1ps
`default_nettype none
module focsr_top_bench;
  import focsr_pkg::*;
  // ==========================================================
  // Signals
  logic        clk = 1'b0;   // 50 MHz system clock
  logic        reset = 1'b1; // Async reset, high
  logic [31:0] flux_ref_in = '0, torque_ref_in = '0; // Engine values
  logic [31:0] sd_speed_in = '0, pd_angle_in = '0;   // Engine values
  logic [15:0] sd_state_in = '0, pd_state_in = '0;   // State codes
  logic [5:0]  we = '0;      // Update strobes, one per register
  logic        sd_done, sd_err, pd_done, pd_err; // Status flags
  logic [13:0] awaddr = '0, araddr = '0; // Byte addresses
  logic        awvalid = 0, awready, wvalid = 0, wready, bvalid;
  logic        bready = 0, arvalid = 0, arready, rvalid, rready = 0;
  logic [31:0] wdata = '0, rdata;  // Bus data
  logic [3:0]  wstrb = 4'hF;       // Byte strobes
  logic [1:0]  bresp, rresp;       // Response codes
  int          mismatches = 0;     // Failed comparisons
  int          checked = 0;        // Comparisons made
  logic [31:0] expv [6] = '{default: '0}; // Model of stored values
  // Register indices and widths, in bus order
  logic [11:0] idx [6] = '{FOCSR_IDX_FLUX, FOCSR_IDX_TORQUE,
    FOCSR_IDX_SDST, FOCSR_IDX_SDSPD, FOCSR_IDX_PDST, FOCSR_IDX_PDANG};
  logic [31:0] msk [6] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0000FFFF,
    32'hFFFFFFFF, 32'h0000FFFF, 32'hFFFFFFFF};
  // ==========================================================
  // Device under test
  focsr_top focsr_top_inst (.clk(clk), .reset(reset),
    .flux_ref_in(flux_ref_in), .flux_ref_we(we[0]),
    .torque_ref_in(torque_ref_in), .torque_ref_we(we[1]),
    .sd_state_in(sd_state_in), .sd_state_we(we[2]),
    .sd_speed_in(sd_speed_in), .sd_speed_we(we[3]),
    .pd_state_in(pd_state_in), .pd_state_we(we[4]),
    .pd_angle_in(pd_angle_in), .pd_angle_we(we[5]),
    .speed_detect_done(sd_done), .speed_detect_error(sd_err),
    .position_detect_done(pd_done), .position_detect_error(pd_err),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  // ==========================================================
  // Clock, and a watchdog sized well past the expected run
  initial forever #10 clk = ~clk;
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, exp, input string m);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, seen, exp);
    end
  endtask
  // Read one word; request held until arready, rready until rvalid
  task automatic rd(input logic [13:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    // No local limit: only the watchdog ends a wait
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk); // Let rready drop before the next request
  endtask
  // Write one word; each half released as soon as it is taken
  task automatic wr(input logic [13:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b1;
    w  = 1'b1;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // Wait for both halves and the response; the watchdog ends a hang
    while (aw || w || !bvalid)
    begin
      @(posedge clk);
      if (aw && awready)
      begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready)
      begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  // Engine update: one-cycle strobe, then the model follows
  task automatic eng(input int i, input logic [31:0] v);
    case (i)
      0: flux_ref_in <= v;
      1: torque_ref_in <= v;
      2: sd_state_in <= v[15:0];
      3: sd_speed_in <= v;
      4: pd_state_in <= v[15:0];
      default: pd_angle_in <= v;
    endcase
    we <= 6'h01 << i;
    @(posedge clk);
    we <= 6'h00;
    expv[i] = v & msk[i];
    @(posedge clk);
  endtask
  // Read register i and compare with the model
  task automatic rdchk(input int i);
    logic [31:0] d;
    logic [1:0] r;
    rd({idx[i], 2'b00}, d, r);
    check(d, expv[i], "read value");
    check(32'(r), 32'(FOCSR_RESP_OKAY), "read resp");
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < 6; i++) rdchk(i);
    check(32'({sd_done, sd_err, pd_done, pd_err}), 32'h0, "flags");
  endtask
  // Signed and wide patterns; 16-bit codes must drop upper bits
  task automatic t_values();
    for (int i = 0; i < 6; i++)
    begin
      eng(i, 32'hF0A5_5A0F + i);
      rdchk(i);
    end
  endtask
  // Every state code, with the derived done and error levels
  task automatic t_codes();
    for (int c = 0; c <= 6; c++)
    begin
      eng(2, 32'(c)); rdchk(2);
      check(32'(sd_done), 32'(16'(c) == FOCSR_SD_DONE), "sd done");
      check(32'(sd_err), 32'(16'(c) == FOCSR_SD_ERROR), "sd err");
    end
    for (int c = 0; c <= 12; c++)
    begin
      eng(4, 32'(c)); rdchk(4);
      check(32'(pd_done), 32'(16'(c) == FOCSR_PD_DONE), "pd done");
      check(32'(pd_err), 32'(16'(c) == FOCSR_PD_ERROR), "pd err");
    end
  endtask
  // Host writes refused and harmless; unmapped read refused
  task automatic t_readonly();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 6; i++)
    begin
      wr({idx[i], 2'b00}, ~expv[i], r);
      check(32'(r), 32'(FOCSR_RESP_SLVERR), "write resp");
      rdchk(i);
    end
    rd(14'h0004, d, r);
    check(d, 32'h0, "unmapped data");
    check(32'(r), 32'(FOCSR_RESP_SLVERR), "unmapped resp");
  endtask
  // Back-to-back engine strobes: the later value wins
  task automatic t_latest();
    flux_ref_in <= 32'h1111_1111; we <= 6'h01;
    @(posedge clk);
    flux_ref_in <= 32'h8000_0000;
    @(posedge clk);
    we <= 6'h00;
    expv[0] = 32'h8000_0000;
    rdchk(0);
  endtask
  // ==========================================================
  // Verdict and main sequence
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_values();
    t_codes();
    t_readonly();
    t_latest();
    give_verdict();
  end
endmodule // focsr_top_bench
`default_nettype wire
